// ==== verilog/sbd_core.sv ====
/*
  Executes the count-and-skip and unconditional branch instructions.
  Assumes fetch presents the prefetched word each cycle, the file register
  read port answers combinationally, and an outer unit sequences the program counter.
*/
// Functional notes
// [RULE1] Opcode 001011 decrements the file register
// [RULE2] Destination bit picks W or file
// [RULE3] Zero result flushes prefetch, runs one NOP
// [RULE4] Opcode 001111 increments, same zero skip
// [RULE5] Opcode 101 loads literal into PC low
// [RULE6] Latch bits 4:3 fill PC 12:11
// [RULE7] Branch always takes two cycles
// [RULE8] Status flags never change here
`timescale 1ns/1ps
`include "sbd_params.svh"
module sbd_core (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fetch side
  input wire logic [13:0] instr,
  input wire logic [4:0] pc_upper_latch,
  // File register read
  output logic [6:0] file_raddr,
  input wire logic [7:0] file_rdata,
  // Results
  output sbd_pkg::sbd_wr_t file_wr,
  output logic w_we,
  output logic [7:0] w_data,
  output logic pc_load,
  output logic [12:0] pc_target,
  output logic flush,
  output logic status_we,
  output logic busy
);
  import sbd_pkg::*;

  typedef enum logic {sbd_st_exec, sbd_st_bubble} sbd_state_t;

  sbd_dec_t dec;
  sbd_state_t state_reg;
  logic [7:0] result;
  logic exec;

  function automatic logic [7:0] sbd_step(input logic [7:0] v, input logic up);
    sbd_step = up ? v + 8'h01 : v - 8'h01;
  endfunction

  sbd_decode u_dec (
    .instr(instr),
    .dec(dec)
  );

  assign exec = (state_reg == sbd_st_exec);
  assign result = sbd_step(file_rdata, dec.op == sbd_op_inc); // RULE1 RULE4

  always_comb begin
    file_raddr = dec.faddr;
  end

  // Second cycle is a NOP bubble after skip or branch
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= sbd_st_exec;
    end else begin
      unique case (state_reg)
        sbd_st_exec: begin
          if (dec.op == sbd_op_branch) begin
            state_reg <= sbd_st_bubble; // RULE7
          end else if ((dec.op == sbd_op_dec || dec.op == sbd_op_inc) &&
                       result == 8'h00) begin
            state_reg <= sbd_st_bubble; // RULE3
          end
        end
        sbd_st_bubble: state_reg <= sbd_st_exec;
      endcase
    end
  end

  // Result write-back
  always_ff @(posedge clk) begin
    if (rst) begin
      file_wr <= '0;
      w_we <= 1'b0;
      w_data <= 8'h00;
    end else begin
      file_wr.we <= 1'b0;
      w_we <= 1'b0;
      if (exec && (dec.op == sbd_op_dec || dec.op == sbd_op_inc)) begin
        file_wr.we <= dec.dest_file; // RULE2
        file_wr.addr <= dec.faddr;
        file_wr.data <= result;
        w_we <= ~dec.dest_file; // RULE2
        w_data <= result;
      end
    end
  end

  // Program counter and flush
  always_ff @(posedge clk) begin
    if (rst) begin
      pc_load <= 1'b0;
      pc_target <= `SBD_PC_RST;
      flush <= 1'b0;
      busy <= 1'b0;
    end else begin
      pc_load <= 1'b0;
      flush <= 1'b0;
      busy <= 1'b0;
      if (exec && dec.op == sbd_op_branch) begin
        pc_load <= 1'b1;
        pc_target <= {pc_upper_latch[`SBD_LATCH_MSB:`SBD_LATCH_LSB], dec.lit}; // RULE5 RULE6
        flush <= 1'b1; // RULE7
        busy <= 1'b1;
      end else if (exec && (dec.op == sbd_op_dec || dec.op == sbd_op_inc) &&
                   result == 8'h00) begin
        flush <= 1'b1; // RULE3
        busy <= 1'b1;
      end
    end
  end

  // Flags untouched
  always_ff @(posedge clk) begin
    if (rst) begin
      status_we <= 1'b0;
    end else begin
      status_we <= 1'b0; // RULE8
    end
  end

  property p_skip_flush;
    @(posedge clk) disable iff (rst)
      (exec && (dec.op == sbd_op_dec || dec.op == sbd_op_inc) && result == 8'h00)
      |=> flush && !pc_load ##1 !flush;
  endproperty
  a_skip_flush: assert property (p_skip_flush) else $error("skip did not flush once"); // RULE3

  property p_noskip;
    @(posedge clk) disable iff (rst)
      (exec && (dec.op == sbd_op_dec || dec.op == sbd_op_inc) && result != 8'h00) |=> !flush;
  endproperty
  a_noskip: assert property (p_noskip) else $error("flush without zero"); // RULE3

  property p_dec_value;
    @(posedge clk) disable iff (rst)
      (exec && dec.op == sbd_op_dec) |=> (w_data == $past(file_rdata) - 8'h01);
  endproperty
  a_dec_value: assert property (p_dec_value) else $error("decrement wrong"); // RULE1

  property p_inc_value;
    @(posedge clk) disable iff (rst)
      (exec && dec.op == sbd_op_inc) |=> (w_data == $past(file_rdata) + 8'h01);
  endproperty
  a_inc_value: assert property (p_inc_value) else $error("increment wrong"); // RULE4

  property p_dest;
    @(posedge clk) disable iff (rst)
      (exec && (dec.op == sbd_op_dec || dec.op == sbd_op_inc))
      |=> (file_wr.we == $past(dec.dest_file)) && (w_we != file_wr.we);
  endproperty
  a_dest: assert property (p_dest) else $error("destination wrong"); // RULE2

  property p_branch_low;
    @(posedge clk) disable iff (rst)
      (exec && dec.op == sbd_op_branch) |=> pc_load && pc_target[10:0] == $past(instr[10:0]);
  endproperty
  a_branch_low: assert property (p_branch_low) else $error("branch low bits wrong"); // RULE5

  property p_branch_high;
    @(posedge clk) disable iff (rst)
      (exec && dec.op == sbd_op_branch) |=> pc_target[12:11] == $past(pc_upper_latch[4:3]);
  endproperty
  a_branch_high: assert property (p_branch_high) else $error("branch high bits wrong"); // RULE6

  property p_branch_two;
    @(posedge clk) disable iff (rst)
      (exec && dec.op == sbd_op_branch) |=> flush && !exec ##1 exec && !pc_load;
  endproperty
  a_branch_two: assert property (p_branch_two) else $error("branch not two cycles"); // RULE7

  property p_status;
    @(posedge clk) disable iff (rst) !status_we;
  endproperty
  a_status: assert property (p_status) else $error("status written"); // RULE8

  property p_bubble_quiet;
    @(posedge clk) disable iff (rst)
      !exec |=> !flush && !pc_load && !file_wr.we && !w_we;
  endproperty
  a_bubble_quiet: assert property (p_bubble_quiet) else $error("bubble word executed"); // RULE3

  property p_busy;
    @(posedge clk) disable iff (rst) busy == flush;
  endproperty
  a_busy: assert property (p_busy) else $error("busy differs from flush"); // RULE3

  property p_raddr;
    @(posedge clk) disable iff (rst) file_raddr == instr[`SBD_FADDR_MSB:0];
  endproperty
  a_raddr: assert property (p_raddr) else $error("file read address wrong"); // RULE1

  property p_none;
    @(posedge clk) disable iff (rst)
      (exec && dec.op == sbd_op_none) |=> !flush && !pc_load && !file_wr.we && !w_we;
  endproperty
  a_none: assert property (p_none) else $error("other opcode acted"); // RULE4

  property p_target_hold;
    @(posedge clk) disable iff (rst)
      !pc_load |-> $stable(pc_target);
  endproperty
  a_target_hold: assert property (p_target_hold) else $error("target moved without load"); // RULE5

  property p_rst_quiet;
    @(posedge clk)
      rst |=> !flush && !pc_load && !busy && !file_wr.we && !w_we && pc_target == `SBD_PC_RST;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active after reset"); // RULE7

  c_branch: cover property (@(posedge clk) disable iff (rst) exec && dec.op == sbd_op_branch);
  c_skip: cover property (@(posedge clk) disable iff (rst) flush && !pc_load);
  c_file_wr: cover property (@(posedge clk) disable iff (rst) file_wr.we);
  c_inc_skip: cover property (@(posedge clk) disable iff (rst)
    exec && dec.op == sbd_op_inc && result == 8'h00);
endmodule

// ==== verilog/sbd_params.svh ====
/*
  Encodings, field positions and reset values for the skip and branch decoder.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef SBD_PARAMS_SVH
`define SBD_PARAMS_SVH
`define SBD_OP_DEC_SKIP 6'h0B
`define SBD_OP_INC_SKIP 6'h0F
`define SBD_OP_BRANCH 3'h5
`define SBD_OP6_MSB 13
`define SBD_OP6_LSB 8
`define SBD_OP3_MSB 13
`define SBD_OP3_LSB 11
`define SBD_DEST_BIT 7
`define SBD_FADDR_MSB 6
`define SBD_LIT_MSB 10
`define SBD_LATCH_MSB 4
`define SBD_LATCH_LSB 3
`define SBD_PC_RST 13'h0000
`define SBD_NOP_WORD 14'h0000
`endif

// ==== verilog/sbd_pkg.sv ====
/*
  Types shared by the skip and branch decoder.
  Assumes sbd_params.svh is on the include path.
*/
`include "sbd_params.svh"
package sbd_pkg;
  typedef enum logic [1:0] {
    sbd_op_none,
    sbd_op_dec,
    sbd_op_inc,
    sbd_op_branch
  } sbd_op_t;
  typedef struct packed {
    sbd_op_t op;
    logic dest_file;
    logic [6:0] faddr;
    logic [10:0] lit;
  } sbd_dec_t;
  typedef struct packed {
    logic we;
    logic [6:0] addr;
    logic [7:0] data;
  } sbd_wr_t;
endpackage

// ==== verilog/sbd_decode.sv ====
/*
  Combinational decoder of one 14-bit instruction word.
  Assumes a word from the same clock domain.
*/
`timescale 1ns/1ps
`include "sbd_params.svh"
module sbd_decode (
  // Instruction in
  input wire logic [13:0] instr,
  // Decoded fields
  output sbd_pkg::sbd_dec_t dec
);
  import sbd_pkg::*;
  always_comb begin
    dec.dest_file = instr[`SBD_DEST_BIT];
    dec.faddr = instr[`SBD_FADDR_MSB:0];
    dec.lit = instr[`SBD_LIT_MSB:0];
    if (instr[`SBD_OP6_MSB:`SBD_OP6_LSB] == `SBD_OP_DEC_SKIP) begin
      dec.op = sbd_op_dec; // RULE1
    end else if (instr[`SBD_OP6_MSB:`SBD_OP6_LSB] == `SBD_OP_INC_SKIP) begin
      dec.op = sbd_op_inc; // RULE4
    end else if (instr[`SBD_OP3_MSB:`SBD_OP3_LSB] == `SBD_OP_BRANCH) begin
      dec.op = sbd_op_branch; // RULE5
    end else begin
      dec.op = sbd_op_none;
    end
  end
endmodule

// ==== tb/sbd_testbench.sv ====
/*
  Self-checking bench for sbd_core, driving fetch and file read ports itself.
  Assumes the design's own assertions and the package on the include path.
*/
`timescale 1ns/1ps
module testbench;
  import sbd_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [13:0] instr = 14'h0000;
  logic [4:0] pc_upper_latch = 5'h00;
  logic [7:0] file_rdata = 8'h00;
  logic [6:0] file_raddr;
  sbd_wr_t file_wr;
  logic w_we;
  logic [7:0] w_data;
  logic pc_load;
  logic [12:0] pc_target;
  logic flush;
  logic status_we;
  logic busy;
  int n_fail = 0;
  int compares = 0;

  always #2.5 clk = ~clk;

  sbd_core DUT (.clk(clk), .rst(rst), .instr(instr), .pc_upper_latch(pc_upper_latch),
    .file_raddr(file_raddr), .file_rdata(file_rdata), .file_wr(file_wr), .w_we(w_we),
    .w_data(w_data), .pc_load(pc_load), .pc_target(pc_target), .flush(flush),
    .status_we(status_we), .busy(busy));

  task automatic chk(input string nm, input logic [12:0] e, input logic [12:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [12:0] flags();
    return {7'h00, file_wr.we, w_we, pc_load, flush, busy, status_we};
  endfunction

  // Flags order: file write, W write, PC load, flush, busy, status write
  task automatic op(input logic [13:0] i, input logic [7:0] rd, input logic [4:0] lat,
                    input logic [5:0] ef, input logic [12:0] ev);
    @(posedge clk);
    #1;
    instr = i;
    file_rdata = rd;
    pc_upper_latch = lat;
    #1;
    chk("file_raddr", {6'h00, i[6:0]}, {6'h00, file_raddr});
    @(posedge clk);
    #1;
    instr = ef[2] ? 14'h0B85 : 14'h0000;
    file_rdata = 8'h01;
    chk("flags", {7'h00, ef}, flags());
    if (ef[5]) begin
      chk("file_wr.addr", {6'h00, i[6:0]}, {6'h00, file_wr.addr});
      chk("file_wr.data", ev, {5'h00, file_wr.data});
    end
    if (ef[4]) chk("w_data", ev, {5'h00, w_data});
    if (ef[3]) chk("pc_target", ev, pc_target);
    if (ef[2]) begin
      @(posedge clk);
      #1;
      instr = 14'h0000;
      chk("bubble flags", 13'h0000, flags());
    end
  endtask

  task automatic t_dec();
    op(14'h0B85, 8'h01, 5'h00, 6'b100110, 13'h0000);
    op(14'h0B7F, 8'h00, 5'h00, 6'b010000, 13'h00FF);
    op(14'h0B02, 8'h01, 5'h00, 6'b010110, 13'h0000);
    $display("test dec done");
  endtask

  task automatic t_inc();
    op(14'h0FFF, 8'hFF, 5'h00, 6'b100110, 13'h0000);
    op(14'h0F00, 8'h7F, 5'h00, 6'b010000, 13'h0080);
    op(14'h0F83, 8'h10, 5'h00, 6'b100000, 13'h0011);
    $display("test inc done");
  endtask

  task automatic t_branch();
    op(14'h2FFF, 8'h00, 5'h18, 6'b001110, 13'h1FFF);
    op(14'h2800, 8'h00, 5'h07, 6'b001110, 13'h0000);
    op(14'h2923, 8'h00, 5'h08, 6'b001110, 13'h0923);
    op(14'h2D55, 8'h00, 5'h17, 6'b001110, 13'h1555);
    $display("test branch done");
  endtask

  task automatic t_other();
    op(14'h0985, 8'h01, 5'h1F, 6'b000000, 13'h0000);
    op(14'h0A85, 8'hFF, 5'h1F, 6'b000000, 13'h0000);
    $display("test other done");
  endtask

  task automatic end_sim();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    #1;
    rst = 1'b0;
    chk("reset flags", 13'h0000, flags());
    chk("reset pc_target", 13'h0000, pc_target);
    t_dec();
    t_inc();
    t_branch();
    t_other();
    end_sim();
  end

  initial begin
    #2000;
    n_fail++;
    end_sim();
  end
endmodule
